// [common/slc_pkg.sv]
// shared constants, types and helpers of the logic slice pair
package slc_pkg;

    // ------------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------------
    localparam int SLC_NUM_SLICES = 2;
    localparam int SLC_NUM_LUTS = 4;
    localparam int SLC_NUM_STORE = 8;
    localparam int SLC_NUM_LATCH = 4;
    localparam int SLC_LUT_INPUTS = 6;
    localparam int SLC_TT_BITS = 64;
    localparam int SLC_HALF_BITS = 5;

    // ------------------------------------------------------------------
    // lut roles in the wide mux tree and bypass pins steering it
    // ------------------------------------------------------------------
    localparam int SLC_LUT_A = 0;
    localparam int SLC_LUT_B = 1;
    localparam int SLC_LUT_C = 2;
    localparam int SLC_LUT_D = 3;
    localparam int SLC_SEL_LOW = 0;
    localparam int SLC_SEL_ALL = 1;
    localparam int SLC_SEL_HIGH = 2;

    // ------------------------------------------------------------------
    // encodings
    // ------------------------------------------------------------------
    localparam logic [1:0] SLC_DSEL_MAIN = 2'h0;
    localparam logic [1:0] SLC_DSEL_SEC = 2'h1;
    localparam logic [1:0] SLC_DSEL_BYPASS = 2'h2;
    localparam logic [1:0] SLC_DSEL_WIDE = 2'h3;
    localparam logic [1:0] SLC_OSEL_SEC = 2'h0;
    localparam logic [1:0] SLC_OSEL_WIDE = 2'h1;
    localparam logic [1:0] SLC_OSEL_XOR = 2'h2;
    localparam logic [1:0] SLC_OSEL_STORE = 2'h3;
    localparam logic force_low_value = 1'h0;
    localparam logic force_high_value = 1'h1;
    localparam logic startup_low_state = 1'h0;
    localparam logic startup_high_state = 1'h1;
    localparam logic [SLC_LUT_INPUTS-1:0] SLC_ADDR_RESET = 6'h00;

    typedef enum logic [2:0] {
        SLC_SR_NONE = 3'h0,
        SLC_SR_SYNC_SET = 3'h1,
        SLC_SR_SYNC_CLR = 3'h3,
        SLC_SR_ASYNC_SET = 3'h2,
        SLC_SR_ASYNC_CLR = 3'h6
    } slc_srmode_e;

    typedef logic [SLC_TT_BITS-1:0] slc_tt_t;
    typedef logic [SLC_LUT_INPUTS-1:0] slc_addr_t;
    typedef logic [1:0] slc_osel_t;

    typedef struct packed {
        logic sclk;
        logic ce;
        logic sr;
    } slc_ctrl_s;

    typedef struct packed {
        logic clk_invert;
        logic ce_used;
        logic sr_used;
        logic set_reset_timing_choice;
    } slc_slicecfg_s;

    typedef struct packed {
        logic used;
        logic latch;
        logic [1:0] storage_input_select;
        logic force_value_select;
        logic init_indep;
        logic init_value;
    } slc_elemcfg_s;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    function automatic slc_srmode_e slc_sr_mode(input slc_slicecfg_s sc, input slc_elemcfg_s ec);
        slc_srmode_e m;
        m = SLC_SR_NONE;
        if (sc.sr_used && sc.set_reset_timing_choice) begin
            m = ec.force_value_select ? SLC_SR_ASYNC_SET : SLC_SR_ASYNC_CLR;
        end else if (sc.sr_used) begin
            m = ec.force_value_select ? SLC_SR_SYNC_SET : SLC_SR_SYNC_CLR;
        end
        return m;
    endfunction

    function automatic logic slc_init_val(input slc_elemcfg_s ec);
        return ec.init_indep ? ec.init_value : ec.force_value_select;
    endfunction

endpackage

// [hdl/slc_lut6.sv]
// one six-input function generator with registered outputs
`timescale 1ns/1ps
module slc_lut6 (
    input wire logic mclk,
    input wire logic rst,
    input wire slc_pkg::slc_tt_t truth,
    input wire slc_pkg::slc_addr_t addr,
    output logic main_r,
    output logic sec_r
);
    import slc_pkg::*;

    logic [SLC_LUT_INPUTS-1:0] low_addr;

    // ------------------------------------------------------------------
    // lookup
    // ------------------------------------------------------------------
    // lower half of the table answers the secondary output
    always_comb begin
        low_addr = {1'h0, addr[SLC_HALF_BITS-1:0]}; // R03 R04
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            main_r <= 1'h0;
            sec_r <= 1'h0;
        end else begin
            main_r <= truth[addr]; // R02
            sec_r <= truth[low_addr]; // R03 R04
        end
    end

endmodule

// [hdl/slc_logic_block.sv]
// logic block: two independent slices of function generators and storage
// Notes on behaviour
// [R01] each slice has four generators, six inputs, main and secondary outputs
// [R02] a generator computes any six-input function on its main output
// [R03] with top input high, two five-input functions, one per output
// [R04] alternatively one three-input and one two-input function
// [R05] main output leaves directly; secondary through a per-generator mux
// [R06] secondary feeds carry chain; main drives xor and carry select
// [R07] two seven-input muxes pair generators a/b and c/d
// [R08] an eight-input mux selects between the two seven-input results
// [R09] no cascade path to another slice beyond eight inputs
// [R10] eight storage elements; four may be latches, four flip-flops only
// [R11] storage input is a generator output or the bypass input
// [R12] latch passes data while clock low, holds while high
// [R13] clock, enable and set/reset are shared by a slice
// [R14] clock polarity selectable; enable and set/reset fixed polarity
// [R15] enable and set/reset are active high
// [R16] set/reset high forces the chosen force value, else normal
// [R17] force value per element; sync or async per slice
// [R18] global set/reset loads each element's initial value at once
// [R19] initial value follows force value unless set independently
// [R20] five set/reset options: none, sync set/clear, async preset/clear
// [R21] two slices with no links and their own carry chain
// [R22] configuration never asks for both set and reset on one element
// [R23] flip-flop captures on active edge with enable high, no set/reset
`timescale 1ns/1ps
module slc_logic_block (
    input wire logic mclk,
    input wire logic rst,
    input wire logic gsr,
    input wire slc_pkg::slc_tt_t [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] lut_tt,
    input wire slc_pkg::slc_addr_t [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] lut_addr,
    input wire logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] bypass_input,
    input wire logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] carry_in,
    input wire slc_pkg::slc_ctrl_s [slc_pkg::SLC_NUM_SLICES-1:0] slice_ctrl,
    input wire slc_pkg::slc_slicecfg_s [slc_pkg::SLC_NUM_SLICES-1:0] slice_cfg,
    input wire slc_pkg::slc_elemcfg_s [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_STORE-1:0] elem_cfg,
    input wire slc_pkg::slc_osel_t [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] secondary_out_select,
    output logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] lut_main_output_r,
    output logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] lut_secondary_output_r,
    output logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] carry_gen_r,
    output logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_LUTS-1:0] carry_sel_r,
    output logic [slc_pkg::SLC_NUM_SLICES-1:0][slc_pkg::SLC_NUM_STORE-1:0] store_r
);
    import slc_pkg::*;

    localparam int NS = SLC_NUM_SLICES;
    localparam int NL = SLC_NUM_LUTS;
    localparam int NF = SLC_NUM_STORE;

    logic [NS-1:0][NL-1:0] main_q;
    logic [NS-1:0][NL-1:0] sec_q;
    logic [NS-1:0][NL-1:0] bypass_r;
    logic [NS-1:0][NL-1:0] carry_r;
    logic [NS-1:0] ce_r;
    logic [NS-1:0] sr_r;
    logic [NS-1:0] clk_s1_r;
    logic [NS-1:0] clk_s2_r;
    logic [NS-1:0] clk_s3_r;
    logic [NS-1:0] wide_low;
    logic [NS-1:0] wide_high;
    logic [NS-1:0] wide_all;
    logic [NS-1:0][NL-1:0] wide_of;
    logic [NS-1:0] act;
    logic [NS-1:0] act_edge;
    logic [NS-1:0] ce_eff;
    logic [NS-1:0][NF-1:0] latch_w;
    logic [NS-1:0][NF-1:0] d_w;
    logic [NS-1:0][NF-1:0] sr_hit;
    logic [NS-1:0][NF-1:0] open_w;
    logic [NS-1:0][NF-1:0] init_w;
    slc_srmode_e [NS-1:0][NF-1:0] mode_w;

    // ------------------------------------------------------------------
    // function generators
    // ------------------------------------------------------------------
    genvar gs;
    genvar gl;
    for (gs = 0; gs < NS; gs++) begin : g_slice
        for (gl = 0; gl < NL; gl++) begin : g_lut
            slc_lut6 u_lut (
                .mclk(mclk),
                .rst(rst),
                .truth(lut_tt[gs][gl]),
                .addr(lut_addr[gs][gl]),
                .main_r(main_q[gs][gl]),
                .sec_r(sec_q[gs][gl])
            ); // R01
        end
    end

    // ------------------------------------------------------------------
    // input alignment and slice clock synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            bypass_r <= '0;
            carry_r <= '0;
            ce_r <= '0;
            sr_r <= '0;
        end else begin
            bypass_r <= bypass_input;
            carry_r <= carry_in;
            for (int s = 0; s < NS; s++) begin
                ce_r[s] <= slice_ctrl[s].ce; // R13
                sr_r[s] <= slice_ctrl[s].sr; // R13
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            clk_s1_r <= '0;
            clk_s2_r <= '0;
            clk_s3_r <= '0;
        end else begin
            for (int s = 0; s < NS; s++) begin
                clk_s1_r[s] <= slice_ctrl[s].sclk;
            end
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
        end
    end

    // ------------------------------------------------------------------
    // wide muxes and shared controls
    // ------------------------------------------------------------------
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            // each slice uses only its own generators
            wide_low[s] = bypass_r[s][SLC_SEL_LOW] ? main_q[s][SLC_LUT_B] : main_q[s][SLC_LUT_A]; // R07 R21
            wide_high[s] = bypass_r[s][SLC_SEL_HIGH] ? main_q[s][SLC_LUT_D] : main_q[s][SLC_LUT_C]; // R07
            wide_all[s] = bypass_r[s][SLC_SEL_ALL] ? wide_high[s] : wide_low[s]; // R08 R09
            wide_of[s][SLC_LUT_A] = wide_low[s];
            wide_of[s][SLC_LUT_B] = wide_all[s];
            wide_of[s][SLC_LUT_C] = wide_high[s];
            wide_of[s][SLC_LUT_D] = wide_all[s];
            act[s] = clk_s2_r[s] ^ slice_cfg[s].clk_invert; // R14
            act_edge[s] = act[s] & ~(clk_s3_r[s] ^ slice_cfg[s].clk_invert); // R14
            ce_eff[s] = ~slice_cfg[s].ce_used | ce_r[s]; // R13 R15
        end
    end

    // ------------------------------------------------------------------
    // per-element decode
    // ------------------------------------------------------------------
    always_comb begin
        for (int s = 0; s < NS; s++) begin
            for (int f = 0; f < NF; f++) begin
                latch_w[s][f] = (f < SLC_NUM_LATCH) ? elem_cfg[s][f].latch : 1'h0; // R10
                mode_w[s][f] = slc_sr_mode(slice_cfg[s], elem_cfg[s][f]); // R20 R22
                init_w[s][f] = slc_init_val(elem_cfg[s][f]); // R19
                open_w[s][f] = latch_w[s][f] ? ~act[s] : act_edge[s]; // R12
                unique case (elem_cfg[s][f].storage_input_select) // R11
                    SLC_DSEL_MAIN: d_w[s][f] = main_q[s][f % NL];
                    SLC_DSEL_SEC: d_w[s][f] = sec_q[s][f % NL];
                    SLC_DSEL_BYPASS: d_w[s][f] = bypass_r[s][f % NL];
                    SLC_DSEL_WIDE: d_w[s][f] = wide_of[s][f % NL];
                endcase
                unique case (mode_w[s][f]) // R17
                    SLC_SR_NONE: sr_hit[s][f] = 1'h0;
                    SLC_SR_SYNC_SET, SLC_SR_SYNC_CLR: sr_hit[s][f] = sr_r[s] & open_w[s][f];
                    SLC_SR_ASYNC_SET, SLC_SR_ASYNC_CLR: sr_hit[s][f] = sr_r[s];
                    default: sr_hit[s][f] = 1'h0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // storage elements
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        for (int s = 0; s < NS; s++) begin
            for (int f = 0; f < NF; f++) begin
                if (rst || gsr) begin
                    store_r[s][f] <= init_w[s][f] ? startup_high_state : startup_low_state; // R18 R19
                end else if (!elem_cfg[s][f].used) begin
                    store_r[s][f] <= store_r[s][f];
                end else if (sr_hit[s][f]) begin
                    store_r[s][f] <= elem_cfg[s][f].force_value_select ? force_high_value : force_low_value; // R16
                end else if (open_w[s][f] && ce_eff[s]) begin
                    store_r[s][f] <= d_w[s][f]; // R12 R23
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // slice outputs
    // ------------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            lut_main_output_r <= '0;
            carry_gen_r <= '0;
            carry_sel_r <= '0;
        end else begin
            lut_main_output_r <= main_q; // R05
            carry_gen_r <= sec_q; // R06
            carry_sel_r <= main_q; // R06
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            lut_secondary_output_r <= '0;
        end else begin
            for (int s = 0; s < NS; s++) begin
                for (int i = 0; i < NL; i++) begin
                    unique case (secondary_out_select[s][i]) // R05
                        SLC_OSEL_SEC: lut_secondary_output_r[s][i] <= sec_q[s][i];
                        SLC_OSEL_WIDE: lut_secondary_output_r[s][i] <= wide_of[s][i];
                        SLC_OSEL_XOR: lut_secondary_output_r[s][i] <= main_q[s][i] ^ carry_r[s][i]; // R06
                        SLC_OSEL_STORE: lut_secondary_output_r[s][i] <= store_r[s][i + SLC_NUM_LATCH];
                    endcase
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    for (gs = 0; gs < NS; gs++) begin : g_chk
        for (gl = 0; gl < NL; gl++) begin : g_lchk
            chk_lut_main_path: assert property ( // R02
                !$past(rst) && !$past(rst, 2) |->
                lut_main_output_r[gs][gl] == $past(lut_tt[gs][gl][lut_addr[gs][gl]], 2))
                else $error("main output does not follow the table");
            chk_lut_dual_half: assert property ( // R03
                lut_addr[gs][gl][SLC_HALF_BITS] |-> ##2
                carry_gen_r[gs][gl] == $past(lut_tt[gs][gl][{1'h0, lut_addr[gs][gl][SLC_HALF_BITS-1:0]}], 2))
                else $error("secondary output wrong in dual mode");
            chk_xor_path: assert property ( // R06
                !$past(rst) && secondary_out_select[gs][gl] == SLC_OSEL_XOR |=>
                lut_secondary_output_r[gs][gl] == (lut_main_output_r[gs][gl] ^ $past(carry_in[gs][gl], 2)))
                else $error("xor option output wrong");
            chk_store_route: assert property ( // R05
                secondary_out_select[gs][gl] == SLC_OSEL_STORE |=>
                lut_secondary_output_r[gs][gl] == $past(store_r[gs][gl + SLC_NUM_LATCH]))
                else $error("stored value not routed out");
        end
        chk_wide_low_pair: assert property ( // R07
            secondary_out_select[gs][SLC_LUT_A] == SLC_OSEL_WIDE |=>
            lut_secondary_output_r[gs][SLC_LUT_A] ==
            $past(main_q[gs][bypass_r[gs][SLC_SEL_LOW] ? SLC_LUT_B : SLC_LUT_A]))
            else $error("low pair mux output wrong");
        chk_wide_all_four: assert property ( // R08
            secondary_out_select[gs][SLC_LUT_B] == SLC_OSEL_WIDE |=>
            lut_secondary_output_r[gs][SLC_LUT_B] ==
            $past(bypass_r[gs][SLC_SEL_ALL] ?
            main_q[gs][bypass_r[gs][SLC_SEL_HIGH] ? SLC_LUT_D : SLC_LUT_C] :
            main_q[gs][bypass_r[gs][SLC_SEL_LOW] ? SLC_LUT_B : SLC_LUT_A]))
            else $error("eight-input mux output wrong");
        for (gl = 0; gl < NF; gl++) begin : g_fchk
            chk_latch_hold: assert property ( // R12
                latch_w[gs][gl] && elem_cfg[gs][gl].used && act[gs] && !sr_r[gs] && !gsr |=>
                $stable(store_r[gs][gl]))
                else $error("latch changed while clock high");
            chk_ff_capture: assert property ( // R23
                !latch_w[gs][gl] && elem_cfg[gs][gl].used && act_edge[gs] && ce_eff[gs]
                && !sr_hit[gs][gl] && !gsr |=> store_r[gs][gl] == $past(d_w[gs][gl]))
                else $error("flip-flop missed its capture");
            chk_sr_force: assert property ( // R16
                elem_cfg[gs][gl].used && slice_cfg[gs].sr_used && sr_r[gs]
                && slice_cfg[gs].set_reset_timing_choice && !gsr |=>
                store_r[gs][gl] == $past(elem_cfg[gs][gl].force_value_select))
                else $error("set/reset did not force value");
            chk_gsr_init: assert property ( // R18
                gsr |=> store_r[gs][gl] == $past(init_w[gs][gl]))
                else $error("global set/reset did not load init");
            chk_ce_hold: assert property ( // R15
                !latch_w[gs][gl] && slice_cfg[gs].ce_used && !ce_r[gs] && !sr_r[gs] && !gsr |=>
                $stable(store_r[gs][gl]))
                else $error("element moved with enable low");
            chk_sync_wait: assert property ( // R17
                !latch_w[gs][gl] && !act_edge[gs] && !slice_cfg[gs].set_reset_timing_choice
                && !gsr |=> $stable(store_r[gs][gl]))
                else $error("synchronous element moved without edge");
        end
        cov_ff_capture: cover property (act_edge[gs] && ce_eff[gs] && !sr_r[gs] && elem_cfg[gs][0].used);
        cov_async_force: cover property (sr_r[gs] && slice_cfg[gs].set_reset_timing_choice);
        cov_latch_open: cover property (latch_w[gs][0] && elem_cfg[gs][0].used && !act[gs] ##1 act[gs]);
        cov_wide_high: cover property (bypass_r[gs][SLC_SEL_ALL] && secondary_out_select[gs][SLC_LUT_B] == SLC_OSEL_WIDE);
    end

endmodule

// [bench/slc_route_model.sv]
// model of the surrounding routing that drives the slice clock
`timescale 1ns/1ps
module slc_route_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic go,
    output logic sclk,
    output logic busy
);
    logic [3:0] cnt_r;
    // ----------------------------------------
    // one slow clock period per request
    // ----------------------------------------
    always_ff @(posedge mclk) begin
        if (rst) begin
            cnt_r <= 4'h0;
        end else if (go && cnt_r == 4'h0) begin
            cnt_r <= 4'h8;
        end else if (cnt_r != 4'h0) begin
            cnt_r <= cnt_r - 4'h1;
        end
    end
    // high four cycles, then low; still between requests
    assign sclk = cnt_r > 4'h4;
    assign busy = cnt_r != 4'h0;
endmodule

// [bench/test_slc_logic_block.sv]
// self-checking bench of the logic slice pair
`timescale 1ns/1ps
module test_slc_logic_block;
    import slc_pkg::*;
    // ----------------------------------------
    // signals
    // ----------------------------------------
    logic mclk, rst, gsr, go, sclk, busy;
    slc_tt_t [1:0][3:0] lut_tt;
    slc_addr_t [1:0][3:0] lut_addr;
    logic [1:0][3:0] bypass_input, carry_in, lut_main_output_r;
    logic [1:0][3:0] lut_secondary_output_r, carry_gen_r, carry_sel_r;
    slc_ctrl_s [1:0] slice_ctrl;
    slc_slicecfg_s [1:0] slice_cfg;
    slc_elemcfg_s [1:0][7:0] elem_cfg;
    slc_osel_t [1:0][3:0] secondary_out_select;
    logic [1:0][7:0] store_r;
    logic [1:0] ce_v, setrst_v;
    int miscompares, comparisons;
    assign slice_ctrl = {sclk, ce_v[1], setrst_v[1], sclk, ce_v[0], setrst_v[0]};
    always #5 mclk = ~mclk;
    slc_logic_block slc_logic_block_i (
        .mclk(mclk), .rst(rst), .gsr(gsr), .lut_tt(lut_tt), .lut_addr(lut_addr),
        .bypass_input(bypass_input), .carry_in(carry_in), .slice_ctrl(slice_ctrl),
        .slice_cfg(slice_cfg), .elem_cfg(elem_cfg), .secondary_out_select(secondary_out_select),
        .lut_main_output_r(lut_main_output_r), .lut_secondary_output_r(lut_secondary_output_r),
        .carry_gen_r(carry_gen_r), .carry_sel_r(carry_sel_r), .store_r(store_r));
    slc_route_model slc_route_model_i (.mclk(mclk), .rst(rst), .go(go), .sclk(sclk), .busy(busy));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic mo(int s, int l);
        return lut_tt[s][l][lut_addr[s][l]];
    endfunction
    function automatic logic so(int s, int l);
        return lut_tt[s][l][{1'b0, lut_addr[s][l][4:0]}];
    endfunction
    task automatic report_and_stop();
        $display("counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic cst(input string what, input logic [7:0] e);
        chk(what, e, store_r[0]);
        chk(what, e, store_r[1]);
    endtask
    task automatic wt(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic cfg(input logic inv, sru, asy, ind, lat, input logic [7:0] frc, ini);
        for (int s = 0; s < 2; s++) begin
            slice_cfg[s] <= '{inv, 1'b1, sru, asy};
            for (int f = 0; f < 8; f++) begin
                elem_cfg[s][f] <= '{1'b1, lat, SLC_DSEL_BYPASS, frc[f], ind, ini[f]};
            end
        end
    endtask
    task automatic pulse();
        int n;
        n = 0;
        @(posedge mclk);
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        @(negedge mclk);
        while (busy !== 1'b0) begin
            @(negedge mclk);
            n++;
            if (n > 40) begin
                miscompares++;
                report_and_stop();
            end
        end
        wt(2);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_lut();
        logic [3:0] m, x;
        for (int k = 0; k < 8; k++) begin
            @(posedge mclk);
            for (int s = 0; s < 2; s++) begin
                for (int l = 0; l < 4; l++) begin
                    lut_addr[s][l] <= slc_addr_t'(k * 9 + l * 21 + 5);
                end
            end
            wt(3);
            for (int s = 0; s < 2; s++) begin
                for (int l = 0; l < 4; l++) begin
                    m[l] = mo(s, l);
                    x[l] = so(s, l);
                end
                chk("main", {4'h0, m}, {4'h0, lut_main_output_r[s]});
                chk("carry select", {4'h0, m}, {4'h0, carry_sel_r[s]});
                chk("secondary", {4'h0, x}, {4'h0, lut_secondary_output_r[s]});
                chk("carry gen", {4'h0, x}, {4'h0, carry_gen_r[s]});
            end
        end
        $display("test lut done");
    endtask
    task automatic t_wide();
        logic lo, hi, al;
        logic [3:0] x;
        @(posedge mclk);
        secondary_out_select[0] <= {4{SLC_OSEL_WIDE}};
        secondary_out_select[1] <= {4{SLC_OSEL_XOR}};
        for (int b = 0; b < 8; b++) begin
            @(posedge mclk);
            bypass_input[0] <= 4'(b);
            carry_in[1] <= 4'(b * 3);
            wt(3);
            lo = bypass_input[0][0] ? mo(0, 1) : mo(0, 0);
            hi = bypass_input[0][2] ? mo(0, 3) : mo(0, 2);
            al = bypass_input[0][1] ? hi : lo;
            for (int l = 0; l < 4; l++) begin
                x[l] = mo(1, l) ^ carry_in[1][l];
            end
            chk("wide", {4'h0, al, hi, al, lo}, {4'h0, lut_secondary_output_r[0]});
            chk("xor", {4'h0, x}, {4'h0, lut_secondary_output_r[1]});
        end
        $display("test wide done");
    endtask
    task automatic t_flop();
        @(posedge mclk);
        ce_v <= 2'b00;
        bypass_input <= {2{4'hA}};
        pulse();
        cst("enable off", 8'h00);
        @(posedge mclk);
        ce_v <= 2'b11;
        pulse();
        cst("capture", 8'hAA);
        @(posedge mclk);
        bypass_input <= {2{4'h5}};
        pulse();
        cst("capture", 8'h55);
        $display("test flop done");
    endtask
    task automatic t_setrst();
        @(posedge mclk);
        cfg(0, 1, 0, 0, 0, 8'h0F, 8'h00);
        setrst_v <= 2'b11;
        wt(6);
        cst("sync wait", 8'h55);
        pulse();
        cst("sync force", 8'h0F);
        @(posedge mclk);
        cfg(0, 1, 1, 0, 0, 8'hF0, 8'h00);
        wt(6);
        cst("async force", 8'hF0);
        @(posedge mclk);
        setrst_v <= 2'b00;
        pulse();
        cst("normal", 8'h55);
        $display("test set reset done");
    endtask
    task automatic t_latch();
        @(posedge mclk);
        cfg(0, 0, 0, 0, 1, 8'h00, 8'h00);
        bypass_input <= {2{4'h3}};
        wt(5);
        cst("transparent", 8'h53);
        @(posedge mclk);
        cfg(1, 0, 0, 0, 1, 8'h00, 8'h00);
        wt(5);
        @(posedge mclk);
        bypass_input <= {2{4'hC}};
        wt(5);
        chk("latch hold", 8'h03, {4'h0, store_r[0][3:0]});
        chk("latch hold", 8'h03, {4'h0, store_r[1][3:0]});
        pulse();
        cst("inverted clock", 8'hCC);
        $display("test latch done");
    endtask
    task automatic t_gsr();
        @(posedge mclk);
        cfg(0, 0, 0, 1, 0, 8'h0F, 8'h96);
        gsr <= 1'b1;
        wt(3);
        cst("init own", 8'h96);
        @(posedge mclk);
        cfg(0, 0, 0, 0, 0, 8'h0F, 8'h96);
        wt(3);
        cst("init force", 8'h0F);
        @(posedge mclk);
        gsr <= 1'b0;
        $display("test global init done");
    endtask
    task automatic t_dsel();
        logic [3:0] m, x, w, e;
        for (int d = 0; d < 4; d++) begin
            @(posedge mclk);
            secondary_out_select <= {8{SLC_OSEL_STORE}};
            for (int f = 0; f < 8; f++) begin
                elem_cfg[0][f].storage_input_select <= 2'(d);
                elem_cfg[1][f].storage_input_select <= 2'(d);
            end
            pulse();
            for (int s = 0; s < 2; s++) begin
                for (int l = 0; l < 4; l++) begin
                    m[l] = mo(s, l);
                    x[l] = so(s, l);
                end
                w[0] = bypass_input[s][0] ? m[1] : m[0];
                w[2] = bypass_input[s][2] ? m[3] : m[2];
                w[1] = bypass_input[s][1] ? w[2] : w[0];
                w[3] = w[1];
                e = 2'(d) == SLC_DSEL_MAIN ? m : 2'(d) == SLC_DSEL_SEC ? x : 2'(d) == SLC_DSEL_WIDE ? w : bypass_input[s];
                chk("store input", {e, e}, store_r[s]);
                chk("store route", {4'h0, e}, {4'h0, lut_secondary_output_r[s]});
            end
        end
        $display("test input select done");
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        miscompares = 0;
        comparisons = 0;
        mclk = 1'b0;
        rst = 1'b1;
        gsr = 1'b0;
        go = 1'b0;
        ce_v = 2'b00;
        setrst_v = 2'b00;
        lut_tt[0] = {64'h0123_4567_89AB_CDEF, 64'hFFFF_0000_FF00_F0F0, 64'h6996_9669_9669_6996,
            64'h8000_0000_0000_0001};
        lut_tt[1] = ~lut_tt[0];
        lut_addr = '0;
        bypass_input = '0;
        carry_in = '0;
        secondary_out_select = '0;
        cfg(0, 0, 0, 0, 0, 8'h00, 8'h00);
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        wt(1);
        cst("reset", 8'h00);
        t_lut();
        t_wide();
        t_flop();
        t_setrst();
        t_latch();
        t_gsr();
        t_dsel();
        report_and_stop();
    end
endmodule
